// ### dv/rcf_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// core program counter stand-in
// ------------------------------------------------------------
module rcf_core_model (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        in_sleep_i,
    input  wire logic        pc_load_i,
    input  wire logic [14:0] pc_value_i,
    input  wire logic        vec_i,
    output logic      [14:0] pc_o
);
    logic [14:0] pc_q;
    logic        vec_q;
    assign pc_o = pc_q;
    // pc holds while asleep, so a wake target is pc+1 of a still value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pc_q  <= 15'h0;
            vec_q <= 1'h0;
        end else if (pc_load_i) begin
            pc_q  <= pc_value_i;
            vec_q <= vec_i;
        end else if (vec_q) begin
            pc_q  <= 15'h0004;
            vec_q <= 1'h0;
        end else if (!in_sleep_i) begin
            pc_q <= pc_q + 15'h1;
        end
    end
endmodule : rcf_core_model

// ### dv/reset_cause_flags_tb_top.sv
`timescale 1ns/1ps
module reset_cause_flags_tb_top;
    typedef struct {
        int ev; logic sl; logic ien; logic [7:0] pwr; logic [7:0] st;
        logic wk;
    } rcf_row_t;
    logic        clk_i, sys_rst_i, sleep, irq_en, pc_load, vec, irq;
    logic [7:0]  ev, awaddr, araddr;
    logic [14:0] pc_val, pc;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          n_errors, num_checks, i;
    rcf_row_t    rows[10];

    rcf_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_evt_i(ev[0]),
        .brown_evt_i(ev[1]), .ext_pin_rst_i(ev[2]), .wdog_timeout_i(ev[3]),
        .stack_over_i(ev[4]), .stack_under_i(ev[5]), .reset_instr_i(ev[6]),
        .irq_wake_i(ev[7]), .in_sleep_i(sleep), .global_irq_enable_i(irq_en),
        .pc_i(pc), .pc_load_o(pc_load), .pc_value_o(pc_val),
        .vec_after_next_o(vec), .irq_o(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    rcf_core_model u_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .in_sleep_i(sleep), .pc_load_i(pc_load), .pc_value_i(pc_val),
        .vec_i(vec), .pc_o(pc));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // bready/rready stay high, so no strobe is lowered and raised at once
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int k;
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (k == 40) begin n_errors++; summarize(); end
        chk("bresp", 32'(bresp), 32'(er));
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] er);
        int k;
        araddr <= a; arvalid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (k == 40) begin n_errors++; summarize(); end
        chk("rresp", 32'(rresp), 32'(er));
        chk("rdata", rdata, exp);
    endtask : axr
    task automatic fire(input int k, input logic sl, g, wk, ld);
        logic [14:0] e;
        ev[k] <= 1'h1; sleep <= sl; irq_en <= g;
        @(posedge clk_i);
        e = wk ? pc + 15'h1 : 15'h0;
        ev <= 8'h00;
        // pc_load and vec stand for one cycle only: look while they stand
        #1;
        chk("pc_load", 32'(pc_load), 32'(ld));
        if (ld) chk("pc_value", 32'(pc_val), 32'(e));
        chk("vec", 32'(vec), 32'(g & wk));
        @(posedge clk_i);
        @(posedge clk_i);
    endtask : fire

    initial begin clk_i = 1'b0; forever #4 clk_i = ~clk_i; end

    initial begin
        sys_rst_i = 1'h1; sleep = 1'h0; irq_en = 1'h0; ev = 8'h00;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
        awvalid = 1'h0; wvalid = 1'h0; arvalid = 1'h0;
        bready = 1'h1; rready = 1'h1;
        rows = '{'{6, 0, 0, 8'h0b, 8'h18, 0}, '{2, 0, 0, 8'h03, 8'h18, 0},
                 '{3, 0, 0, 8'h03, 8'h08, 0}, '{4, 0, 0, 8'h83, 8'h08, 0},
                 '{5, 0, 0, 8'hc3, 8'h08, 0}, '{7, 1, 1, 8'hc3, 8'h10, 1},
                 '{3, 1, 0, 8'hc3, 8'h00, 1}, '{2, 1, 0, 8'hc3, 8'h10, 0},
                 '{1, 0, 0, 8'h0e, 8'h18, 0}, '{0, 0, 0, 8'h0c, 8'h18, 0}};
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h0c, 2'h0);
        axr(rcf_pkg::OFS_CORE_STAT, 32'h18, 2'h0);
        axr(rcf_pkg::OFS_CONFIG, 32'h01, 2'h0);
        axr(rcf_pkg::OFS_IRQ_MASK, 32'h00, 2'h0);
        axw(rcf_pkg::OFS_PWR_CTRL, 32'h0f, 2'h0);
        $display("reset test done");
        for (i = 0; i < 10; i++) begin
            fire(rows[i].ev, rows[i].sl, rows[i].ien, rows[i].wk, 1'h1);
            axr(rcf_pkg::OFS_PWR_CTRL, 32'(rows[i].pwr), 2'h0);
            axr(rcf_pkg::OFS_CORE_STAT, 32'(rows[i].st), 2'h0);
            $display("row %0d done", i);
        end
        // every event has been seen at least once; a read empties the status
        axr(rcf_pkg::OFS_IRQ_STAT, 32'hff, 2'h0);
        axr(rcf_pkg::OFS_IRQ_STAT, 32'h00, 2'h0);
        axw(rcf_pkg::OFS_IRQ_MASK, 32'h80, 2'h0);
        fire(6, 1'h0, 1'h0, 1'h0, 1'h1);
        chk("irq masked", 32'(irq), 32'h0);
        fire(7, 1'h1, 1'h0, 1'h1, 1'h1);
        chk("irq", 32'(irq), 32'h1);
        axr(rcf_pkg::OFS_IRQ_STAT, 32'hc0, 2'h0);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", 32'(irq), 32'h0);
        $display("interrupt test done");
        axw(rcf_pkg::OFS_CONFIG, 32'h00, 2'h0);
        fire(4, 1'h0, 1'h0, 1'h0, 1'h0);
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h08, 2'h0);
        axw(rcf_pkg::OFS_CONFIG, 32'h01, 2'h0);
        axw(rcf_pkg::OFS_PWR_CTRL, 32'hff, 2'h0);
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h0f, 2'h0);
        fire(4, 1'h0, 1'h0, 1'h0, 1'h1);
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h8f, 2'h0);
        axw(rcf_pkg::OFS_PWR_CTRL, 32'h0b, 2'h0);
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h0b, 2'h0);
        axw(rcf_pkg::OFS_PWR_CTRL, 32'h0f, 2'h0);
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h0f, 2'h0);
        $display("firmware write test done");
        axw(8'h14, 32'h01, 2'h2);
        axr(8'h14, 32'h00, 2'h2);
        $display("unmapped test done");
        sys_rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        axr(rcf_pkg::OFS_PWR_CTRL, 32'h0c, 2'h0);
        axr(rcf_pkg::OFS_IRQ_MASK, 32'h00, 2'h0);
        $display("mid-run reset test done");
        summarize();
    end
endmodule : reset_cause_flags_tb_top

// ### hw/rcf_axil_slave.sv
`timescale 1ns/1ps
module rcf_axil_slave (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    rcf_reg_if.bus           rif
);
    logic        aw_q, w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        lane0_q;
    // ------------------------------------------------------------
    // write: address and data taken in either order
    // ------------------------------------------------------------
    // ready flags are flops so the top's bus outputs come from registers
    assign aw_q        = !awready;
    assign w_q         = !wready;
    assign rif.wr_stb  = aw_q && w_q && !bvalid;
    assign rif.wr_addr = awaddr_q;
    assign rif.wdata   = wdata_q;
    assign rif.wlane0  = lane0_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            lane0_q  <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                awready  <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                wdata_q <= wdata;
                lane0_q <= wstrb[0];
            end
            if (rif.wr_stb) begin
                awready <= 1'b1;
                wready  <= 1'b1;
                bvalid  <= 1'b1;
                bresp  <= rif.wr_err ? 2'h2 : 2'h0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // read: data sampled at the address handshake
    // ------------------------------------------------------------
    assign rif.rd_stb  = arvalid && arready;
    assign rif.rd_addr = araddr;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= 2'h0;
        end else if (rif.rd_stb) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rif.rdata;
            rresp   <= rif.rd_err ? 2'h2 : 2'h0;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule : rcf_axil_slave

// ### hw/rcf_irq_status.sv
`timescale 1ns/1ps
module rcf_irq_status #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] evt_i,
    input  wire logic         rd_clr_i,
    input  wire logic         mask_wr_i,
    input  wire logic [W-1:0] mask_i,
    output logic [W-1:0]      status_o,
    output logic [W-1:0]      mask_o,
    output logic              irq_o
);
    logic [W-1:0] status_d, mask_d;
    // an event landing with the read-clear stays set
    assign status_d = (rd_clr_i ? '0 : status_o) | evt_i;
    assign mask_d   = mask_wr_i ? mask_i : mask_o;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status_o <= '0;
            mask_o   <= '0;
            irq_o    <= 1'b0;
        end else begin
            status_o <= status_d;
            mask_o   <= mask_d;
            irq_o    <= |(status_d & mask_d);
        end
    end
endmodule : rcf_irq_status

// ### hw/rcf_top.sv
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Functional notes
// - every reset or wake updates cause bits
// - power-on: pc 0, timeout and powerdown set
// - brown-out: pc 0, timeout set, brownout cleared
// - watchdog clears timeout; sleep wake also powerdown
// - interrupt wake: timeout 1, powerdown 0, next
// - interrupt wake with irq enable: next, then vector
// - pin reset clears pin flag; sleep sets timeout
// - reset instruction clears soft flag only
// - enabled stack overflow sets overflow flag
// - enabled stack underflow sets underflow flag
// - stack flags hardware set, firmware zero clears
// - six flags, bits 5 and 4 zero
// - pin flag hardware cleared, firmware set
// - unimplemented status bits read zero
// - stack faults reset only when enabled
// ----------------------------------------------------------------
module rcf_top #(
    parameter int PC_W = 15
) (
    input  wire logic            clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic            por_evt_i,
    input  wire logic            brown_evt_i,
    input  wire logic            ext_pin_rst_i,
    input  wire logic            wdog_timeout_i,
    input  wire logic            reset_instr_i,
    input  wire logic            stack_over_i,
    input  wire logic            stack_under_i,
    input  wire logic            irq_wake_i,
    input  wire logic            in_sleep_i,
    input  wire logic            global_irq_enable_i,
    input  wire logic [PC_W-1:0] pc_i,
    output logic                 pc_load_o,
    output logic [PC_W-1:0]      pc_value_o,
    output logic                 vec_after_next_o,
    output logic                 irq_o,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready
);
    rcf_reg_if rif ();

    logic [7:0]      pwr_q, pwr_d;
    logic [1:0]      stat_q, stat_d;
    logic            sfr_en_q;
    logic            pc_load_d, vec_d;
    logic [PC_W-1:0] pc_val_d;
    logic [rcf_pkg::EVT_W-1:0] irq_stat, irq_mask;

    // ------------------------------------------------------------
    // bus slave and event status
    // ------------------------------------------------------------
    rcf_axil_slave u_bus (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .awaddr    (s_axi_awaddr),
        .awvalid   (s_axi_awvalid),
        .awready   (s_axi_awready),
        .wdata     (s_axi_wdata),
        .wstrb     (s_axi_wstrb),
        .wvalid    (s_axi_wvalid),
        .wready    (s_axi_wready),
        .bresp     (s_axi_bresp),
        .bvalid    (s_axi_bvalid),
        .bready    (s_axi_bready),
        .araddr    (s_axi_araddr),
        .arvalid   (s_axi_arvalid),
        .arready   (s_axi_arready),
        .rdata     (s_axi_rdata),
        .rresp     (s_axi_rresp),
        .rvalid    (s_axi_rvalid),
        .rready    (s_axi_rready),
        .rif       (rif.bus)
    );

    // ------------------------------------------------------------
    // cause selection
    // ------------------------------------------------------------
    wire ev_ovf  = stack_over_i && sfr_en_q;
    wire ev_unf  = stack_under_i && sfr_en_q;
    wire ev_wake = irq_wake_i && in_sleep_i;
    wire ev_wdog = wdog_timeout_i;
    rcf_pkg::rcf_evt_t sel;
    assign sel = por_evt_i     ? rcf_pkg::EV_POR   :
                 brown_evt_i   ? rcf_pkg::EV_BROWN :
                 ext_pin_rst_i ? rcf_pkg::EV_PIN   :
                 ev_wdog       ? rcf_pkg::EV_WDOG  :
                 ev_ovf        ? rcf_pkg::EV_OVF   :
                 ev_unf        ? rcf_pkg::EV_UNF   :
                 reset_instr_i ? rcf_pkg::EV_SOFT  :
                 ev_wake       ? rcf_pkg::EV_WAKE  : rcf_pkg::EV_NONE;
    wire [rcf_pkg::EVT_W-1:0] evt_vec = {ev_wake, reset_instr_i, ev_unf,
        ev_ovf, ev_wdog, ext_pin_rst_i, brown_evt_i, por_evt_i};

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_pwr  = rif.wr_stb && rif.wlane0
                   && rif.wr_addr == rcf_pkg::OFS_PWR_CTRL;
    wire wr_mask = rif.wr_stb && rif.wlane0
                   && rif.wr_addr == rcf_pkg::OFS_IRQ_MASK;
    wire wr_cfg  = rif.wr_stb && rif.wlane0
                   && rif.wr_addr == rcf_pkg::OFS_CONFIG;
    wire rd_ist  = rif.rd_stb && rif.rd_addr == rcf_pkg::OFS_IRQ_STAT;
    wire wr_ok   = rif.wr_addr == rcf_pkg::OFS_PWR_CTRL
                   || rif.wr_addr == rcf_pkg::OFS_CORE_STAT
                   || rif.wr_addr == rcf_pkg::OFS_IRQ_MASK
                   || rif.wr_addr == rcf_pkg::OFS_CONFIG;
    wire rd_ok   = rif.rd_addr == rcf_pkg::OFS_PWR_CTRL
                   || rif.rd_addr == rcf_pkg::OFS_CORE_STAT
                   || rif.rd_addr == rcf_pkg::OFS_IRQ_STAT
                   || rif.rd_addr == rcf_pkg::OFS_IRQ_MASK
                   || rif.rd_addr == rcf_pkg::OFS_CONFIG;
    assign rif.wr_err = !wr_ok;
    assign rif.rd_err = !rd_ok;
    // status register is read-only; only timeout and powerdown exist
    wire [31:0] stat_word = {27'h0, stat_q, 3'h0};
    wire [31:0] pwr_word  = {24'h0, pwr_q & rcf_pkg::PWR_IMPL_MASK};
    assign rif.rdata =
        rif.rd_addr == rcf_pkg::OFS_PWR_CTRL  ? pwr_word  :
        rif.rd_addr == rcf_pkg::OFS_CORE_STAT ? stat_word :
        rif.rd_addr == rcf_pkg::OFS_IRQ_STAT  ? {24'h0, irq_stat} :
        rif.rd_addr == rcf_pkg::OFS_IRQ_MASK  ? {24'h0, irq_mask} :
        rif.rd_addr == rcf_pkg::OFS_CONFIG    ? {31'h0, sfr_en_q} :
                                                32'h0000_0000;

    // firmware view first; hardware events overlay it below
    wire [7:0] wv = rif.wdata[7:0];
    wire [7:0] pwr_fw = !wr_pwr ? pwr_q :
        {pwr_q[7] & wv[7], pwr_q[6] & wv[6],
         2'h0, wv[3:0]};

    // ------------------------------------------------------------
    // per-cause updates
    // ------------------------------------------------------------
    always_comb begin
        pwr_d     = pwr_fw;
        stat_d    = stat_q;
        pc_load_d = 1'b1;
        pc_val_d  = '0;
        vec_d     = 1'b0;
        case (sel)
            rcf_pkg::EV_POR: begin
                pwr_d  = rcf_pkg::PWR_POR_VAL;
                stat_d = rcf_pkg::STAT_POR_VAL;
            end
            rcf_pkg::EV_BROWN: begin
                pwr_d  = {2'b00, 2'b00, 2'b11, pwr_q[1], 1'b0};
                stat_d = 2'b11;
            end
            rcf_pkg::EV_PIN: begin
                pwr_d[rcf_pkg::BIT_PIN_RST] = 1'b0;
                if (in_sleep_i) begin
                    stat_d = 2'b10;
                end
            end
            rcf_pkg::EV_WDOG: begin
                stat_d[1] = 1'b0;
                if (in_sleep_i) begin
                    stat_d[0] = 1'b0;
                    pc_val_d  = PC_W'(pc_i + 1'b1);
                end
            end
            rcf_pkg::EV_OVF: begin
                pwr_d[rcf_pkg::BIT_STK_OVER] = 1'b1;
            end
            rcf_pkg::EV_UNF: begin
                pwr_d[rcf_pkg::BIT_STK_UNDER] = 1'b1;
            end
            rcf_pkg::EV_SOFT: begin
                pwr_d[rcf_pkg::BIT_SOFT_RST] = 1'b0;
            end
            rcf_pkg::EV_WAKE: begin
                stat_d   = 2'b10;
                pc_val_d = PC_W'(pc_i + 1'b1);
                vec_d    = global_irq_enable_i;
            end
            default: begin
                pc_load_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // flags and pc move on the same edge, so the core never fetches
    // ahead of a half-updated cause record
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwr_q <= rcf_pkg::PWR_POR_VAL;
            stat_q <= rcf_pkg::STAT_POR_VAL;
            sfr_en_q <= rcf_pkg::SFR_EN_RST;
            pc_load_o <= 1'b0;
            pc_value_o <= '0;
            vec_after_next_o <= 1'b0;
        end else begin
            pwr_q <= pwr_d & rcf_pkg::PWR_IMPL_MASK;
            stat_q <= stat_d;
            sfr_en_q <= wr_cfg ? wv[rcf_pkg::BIT_SFR_EN] : sfr_en_q;
            pc_load_o <= pc_load_d;
            pc_value_o <= pc_val_d;
            vec_after_next_o <= vec_d;
        end
    end

    rcf_irq_status #(.W(rcf_pkg::EVT_W)) u_irq (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .evt_i     (evt_vec),
        .rd_clr_i  (rd_ist),
        .mask_wr_i (wr_mask),
        .mask_i    (wv),
        .status_o  (irq_stat),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_por_values: assert property (
        sel == rcf_pkg::EV_POR |=> pc_load_o && pc_value_o == '0
        && pwr_q == 8'h0c && stat_q == 2'b11)
        else $error("power-on cause values wrong");
    chk_brown_values: assert property (
        sel == rcf_pkg::EV_BROWN |=> pwr_q[7:2] == 6'h03
        && !pwr_q[0] && pwr_q[1] == $past(pwr_q[1]) && stat_q[1])
        else $error("brown-out cause values wrong");
    chk_wdog_cause: assert property (
        sel == rcf_pkg::EV_WDOG |=> !stat_q[1]
        && pwr_q == $past(pwr_fw)
        && stat_q[0] == ($past(in_sleep_i) ? 1'b0 : $past(stat_q[0])))
        else $error("watchdog cause values wrong");
    chk_wake_cause: assert property (
        sel == rcf_pkg::EV_WAKE |=> stat_q == 2'b10
        && pc_value_o == PC_W'($past(pc_i) + 1'b1))
        else $error("wake cause values wrong");
    chk_vec_after: assert property (
        vec_after_next_o |-> pc_load_o && pc_value_o != '0
        && $past(global_irq_enable_i))
        else $error("vector request without wake and enable");
    chk_pin_cause: assert property (
        sel == rcf_pkg::EV_PIN |=> !pwr_q[3] && pc_value_o == '0)
        else $error("pin reset flag not cleared");
    chk_soft_cause: assert property (
        sel == rcf_pkg::EV_SOFT |=> !pwr_q[2] && $stable(stat_q))
        else $error("soft reset flag not cleared");
    chk_stack_gate: assert property (
        stack_over_i && !sfr_en_q && sel == rcf_pkg::EV_NONE
        |=> !pc_load_o)
        else $error("disabled stack fault caused restart");
    chk_stack_flags: assert property (
        sel == rcf_pkg::EV_OVF |=> pwr_q[7] ##1 pwr_q[7]
        || $past(wr_pwr))
        else $error("overflow flag not held");
    chk_unused_zero: assert property (
        pwr_q[5:4] == 2'b00 && s_axi_rdata[31:8] == 24'h0)
        else $error("unimplemented bits not zero");

    chk_under_cause: assert property (
        sel == rcf_pkg::EV_UNF |=> pwr_q[6] && pc_load_o
        && pc_value_o == '0 && $stable(stat_q))
        else $error("underflow cause values wrong");

    chk_load_pulse: assert property (
        sel == rcf_pkg::EV_NONE |=> !pc_load_o && !vec_after_next_o)
        else $error("restart without a cause");

    chk_fw_clear: assert property (
        wr_pwr && !wv[7] && sel == rcf_pkg::EV_NONE |=> !pwr_q[7])
        else $error("firmware zero did not clear overflow");

    cov_por:  cover property (sel == rcf_pkg::EV_POR ##1 pc_load_o);
    cov_wake: cover property (vec_after_next_o);
    cov_irq:  cover property (irq_o ##[1:4] !irq_o);
    cov_ovf:  cover property (sel == rcf_pkg::EV_OVF ##2 wr_pwr);
endmodule : rcf_top

// ### pkg/rcf_pkg.sv
package rcf_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PWR_CTRL  = 8'h00;
    localparam logic [7:0] OFS_CORE_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] OFS_CONFIG    = 8'h10;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_STK_OVER  = 7;
    localparam int BIT_STK_UNDER = 6;
    localparam int BIT_PIN_RST   = 3;
    localparam int BIT_SOFT_RST  = 2;
    localparam int BIT_PWR_ON    = 1;
    localparam int BIT_BROWNOUT  = 0;
    localparam int BIT_TIMEOUT   = 4;
    localparam int BIT_PWRDOWN   = 3;
    localparam int BIT_SFR_EN    = 0;
    // implemented bits of the power control register
    localparam logic [7:0] PWR_IMPL_MASK = 8'hcf;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // power-on: stack 00, pin 1, soft 1, power-on 0, brownout picked 0
    localparam logic [7:0] PWR_POR_VAL = 8'h0c;
    localparam logic [1:0] STAT_POR_VAL = 2'h3;
    localparam logic       SFR_EN_RST   = 1'h1;
    localparam int         EVT_W        = 8;
    // ------------------------------------------------------------
    // selected cause: EV_NONE, then highest priority first
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        EV_NONE  = 9'h001,
        EV_POR   = 9'h002,
        EV_BROWN = 9'h004,
        EV_PIN   = 9'h008,
        EV_WDOG  = 9'h010,
        EV_OVF   = 9'h020,
        EV_UNF   = 9'h040,
        EV_SOFT  = 9'h080,
        EV_WAKE  = 9'h100
    } rcf_evt_t;
endpackage : rcf_pkg

// ### pkg/rcf_reg_if.sv
`timescale 1ns/1ps
interface rcf_reg_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  wr_addr;
    logic [7:0]  rd_addr;
    logic [31:0] wdata;
    logic        wlane0;
    logic [31:0] rdata;
    logic        wr_err;
    logic        rd_err;
    modport bus (output wr_stb, rd_stb, wr_addr, rd_addr, wdata, wlane0,
                 input  rdata, wr_err, rd_err);
    modport regs (input  wr_stb, rd_stb, wr_addr, rd_addr, wdata, wlane0,
                  output rdata, wr_err, rd_err);
endinterface : rcf_reg_if
